// *** inc/nvm_pkg.sv ***
// Package of constants and types for the two-wire memory target.
package nvm_pkg;

  // ****************************************
  // Address word and array geometry
  // ****************************************
  // Type code value is arbitrary; set it to the part's real code.
  localparam logic [3:0] NVM_TYPE_CODE = 4'h5;
  localparam int NVM_ADDR_W = 13;
  localparam int NVM_DATA_W = 8;
  localparam int NVM_DEPTH = 8192;
  localparam int NVM_BITS_PER_BYTE = 8;
  localparam logic [3:0] NVM_ACK_BIT = 4'h8;
  localparam logic [3:0] NVM_LAST_DATA_BIT = 4'h7;
  localparam logic NVM_DIR_WRITE = 1'b0;
  localparam logic NVM_DIR_READ = 1'b1;
  localparam logic [12:0] NVM_ADDR_RESET = 13'h0000;

  // ****************************************
  // Protocol states
  // ****************************************
  typedef enum logic [2:0] {
    NVM_IDLE,
    NVM_DEVADDR,
    NVM_ADDR_HI,
    NVM_ADDR_LO,
    NVM_WDATA,
    NVM_RDATA
  } nvm_state_t;

endpackage

// *** inc/nvm_mem_if.sv ***
// Interface between the protocol engine and the storage array.
`timescale 1ns/100ps
interface nvm_mem_if #(
  parameter int AW = 13,
  parameter int DW = 8
);
  logic we;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;

  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface

// *** src/nvm_mem.sv ***
// Storage array with registered read data.
`timescale 1ns/100ps
module nvm_mem #(
  parameter int AW = 13,
  parameter int DW = 8,
  parameter int DEPTH = 8192
) (
  // Clock.
  input wire logic clk,
  // Access port.
  nvm_mem_if.mem port
);

  logic [DW-1:0] mem_q [DEPTH];

  // Write on request and read every cycle; no reset keeps this a plain RAM.
  always_ff @(posedge clk) begin
    if (port.we) begin
      mem_q[port.addr] <= port.wdata;
    end
    port.rdata <= mem_q[port.addr];
  end

endmodule

// *** src/nvm_i2c_slave.sv ***
// Two-wire bus target giving byte access to the storage array.
`timescale 1ns/100ps
// Notes on behaviour
// - First byte: type, strap, direction.
// - Upper four bits match type code.
// - Next three bits match strap pins.
// - Mismatch: no acknowledge, wait next start.
// - Eighth bit: zero write, one read.
// - Matching address word acknowledged low.
// - Write: two address bytes, high first.
// - Each written byte is acknowledged.
// - Read: eight bits out, sample acknowledge.
// - Byte committed at its acknowledge.
// - Protect pin high blocks all writes.
// - Further write bytes go to next addresses.
// - Direct read returns last address plus one.
// - Counter undefined until address loaded.
// - Acknowledged reads continue at next address.
// - Sample on rising, change on falling clock.
// - Stop returns device to standby.
// - Stop before acknowledge abandons operation.
// - Release data line after no-acknowledge.
module nvm_i2c_slave
  import nvm_pkg::*;
#(
  parameter int AW = NVM_ADDR_W,
  parameter int DEPTH = NVM_DEPTH
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Serial bus pins.
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Strap and protect pins.
  input wire logic strap_addr_bit2,
  input wire logic strap_addr_bit1,
  input wire logic strap_addr_bit0,
  input wire logic write_protect
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] scl_sync_q, sda_sync_q, wp_sync_q;
  logic [1:0] s2_sync_q, s1_sync_q, s0_sync_q;
  logic scl_prev_q, sda_prev_q;

  // Two flops per pin; only the second stage feeds the logic.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      wp_sync_q <= 2'h0;
      s2_sync_q <= 2'h0;
      s1_sync_q <= 2'h0;
      s0_sync_q <= 2'h0;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      wp_sync_q <= {wp_sync_q[0], write_protect};
      s2_sync_q <= {s2_sync_q[0], strap_addr_bit2};
      s1_sync_q <= {s1_sync_q[0], strap_addr_bit1};
      s0_sync_q <= {s0_sync_q[0], strap_addr_bit0};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  logic scl, sda, scl_rise, scl_fall, start_det, stop_det;
  logic [2:0] strap;
  assign scl = scl_sync_q[1];
  assign sda = sda_sync_q[1];
  assign strap = {s2_sync_q[1], s1_sync_q[1], s0_sync_q[1]};
  assign scl_rise = scl & ~scl_prev_q;
  assign scl_fall = ~scl & scl_prev_q;
  // Data edges while the clock stays high frame a transaction.
  assign start_det = scl & scl_prev_q & sda_prev_q & ~sda;
  assign stop_det = scl & scl_prev_q & ~sda_prev_q & sda;

  // ****************************************
  // Storage array
  // ****************************************
  nvm_mem_if #(.AW(AW), .DW(NVM_DATA_W)) mem_bus ();

  nvm_mem #(.AW(AW), .DW(NVM_DATA_W), .DEPTH(DEPTH)) u_mem (
    .clk(clk),
    .port(mem_bus)
  );

  // ****************************************
  // Protocol engine
  // ****************************************
  nvm_state_t state_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [AW-1:0] addr_q;
  logic [AW-1:0] hi_q;
  logic ack_drive_q;
  logic data_drive_q;
  logic we_q;
  logic [7:0] wdata_q;

  // Byte just completed by the eighth rising edge, including this bit.
  logic [7:0] rx_byte;
  assign rx_byte = {shift_q[6:0], sda};

  logic match;
  assign match = (rx_byte[7:4] == NVM_TYPE_CODE)
               && (rx_byte[3:1] == strap);

  // Bit counter and receive shift register step on rising edges.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bit_q <= 4'h0;
      shift_q <= 8'h00;
    end else if (start_det || stop_det) begin
      bit_q <= 4'h0;
    end else if (scl_rise && state_q != NVM_IDLE) begin
      shift_q <= rx_byte;
      bit_q <= (bit_q == NVM_ACK_BIT) ? 4'h0 : bit_q + 4'h1;
    end
  end

  // Transaction state moves on the rising edge that ends each phase.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= NVM_IDLE;
    end else if (start_det) begin
      state_q <= NVM_DEVADDR;
    end else if (stop_det) begin
      state_q <= NVM_IDLE;
    end else if (scl_rise) begin
      case (state_q)
        NVM_DEVADDR: begin
          if (bit_q == NVM_LAST_DATA_BIT && !match) begin
            state_q <= NVM_IDLE;
          end else if (bit_q == NVM_ACK_BIT) begin
            state_q <= (shift_q[0] == NVM_DIR_READ) ?
                       NVM_RDATA : NVM_ADDR_HI;
          end
        end
        NVM_ADDR_HI: begin
          if (bit_q == NVM_ACK_BIT) begin
            state_q <= NVM_ADDR_LO;
          end
        end
        NVM_ADDR_LO: begin
          if (bit_q == NVM_ACK_BIT) begin
            state_q <= NVM_WDATA;
          end
        end
        NVM_RDATA: begin
          if (bit_q == NVM_ACK_BIT && sda) begin
            state_q <= NVM_IDLE;
          end
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // Address counter: loaded by the address bytes, stepped per byte.
  // Left at zero after reset; software must not rely on that value.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_q <= NVM_ADDR_RESET;
      hi_q <= NVM_ADDR_RESET;
    end else if (scl_rise && bit_q == NVM_LAST_DATA_BIT) begin
      if (state_q == NVM_ADDR_HI) begin
        // Upper three bits are expected zero and are dropped.
        hi_q <= {rx_byte[AW-9:0], 8'h00};
      end else if (state_q == NVM_ADDR_LO) begin
        addr_q <= hi_q | {{(AW-8){1'b0}}, rx_byte};
      end
    end else if (scl_rise && bit_q == NVM_ACK_BIT &&
                 (state_q == NVM_WDATA || state_q == NVM_RDATA)) begin
      addr_q <= addr_q + 1'b1;
    end
  end

  // Array write issued once the acknowledge clock of a data byte rises.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      we_q <= 1'b0;
      wdata_q <= 8'h00;
    end else begin
      we_q <= 1'b0;
      if (scl_rise && state_q == NVM_WDATA && bit_q == NVM_LAST_DATA_BIT) begin
        wdata_q <= rx_byte;
      end
      if (scl_rise && state_q == NVM_WDATA && bit_q == NVM_ACK_BIT) begin
        we_q <= ~wp_sync_q[1];
      end
    end
  end

  // Protect is applied when the write is launched, one cycle ahead.
  assign mem_bus.we = we_q;
  assign mem_bus.wdata = wdata_q;
  assign mem_bus.addr = we_q ? addr_q - 1'b1 : addr_q;

  // Data line driver changes on falling clock edges and is released at a start or a stop.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_drive_q <= 1'b0;
      data_drive_q <= 1'b0;
      tx_q <= 8'h00;
    end else if (start_det || stop_det) begin
      ack_drive_q <= 1'b0;
      data_drive_q <= 1'b0;
    end else if (scl_fall) begin
      ack_drive_q <= 1'b0;
      data_drive_q <= 1'b0;
      if (bit_q == NVM_ACK_BIT && state_q != NVM_IDLE &&
          state_q != NVM_RDATA) begin
        ack_drive_q <= 1'b1;
      end else if (state_q == NVM_RDATA && bit_q == 4'h0) begin
        // Array read data settled long ago on this slow link.
        tx_q <= {mem_bus.rdata[6:0], 1'b0};
        data_drive_q <= ~mem_bus.rdata[7];
      end else if (state_q == NVM_RDATA && bit_q < NVM_ACK_BIT) begin
        tx_q <= {tx_q[6:0], 1'b0};
        data_drive_q <= ~tx_q[7];
      end
    end
  end

  // Open drain: only a low is ever driven.
  assign sda_o = 1'b0;
  assign sda_oe = ack_drive_q | data_drive_q;

endmodule

// *** verif/nvm_i2c_slave_monitor.sv ***
// Pin-level checker for the two-wire memory target.
`timescale 1ns/100ps
module nvm_i2c_slave_monitor #(
  parameter int AW = 13,
  parameter int DEPTH = 8192
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Bus pins.
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  // Straps and protect.
  input wire logic strap_addr_bit2,
  input wire logic strap_addr_bit1,
  input wire logic strap_addr_bit0,
  input wire logic write_protect
);
  // *****
  // Properties
  // *****
  // One clock domain, so clock and reset are set once.
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_od; sda_oe |-> !sda_o; endproperty
  a_od: assert property (p_od) else $error("sda_o high");
  property p_low; $changed(sda_oe) |-> !scl_i; endproperty
  a_low: assert property (p_low) else $error("oe moved");
  property p_fall; $changed(sda_oe) |-> $past(scl_i, 8); endproperty
  a_fall: assert property (p_fall) else $error("oe late");
  property p_rst; $rose(nrst) |-> !sda_oe [*4]; endproperty
  a_rst: assert property (p_rst) else $error("oe at reset");
  property p_stop; scl_i && $rose(sda_i) |=> !sda_oe [*4]; endproperty
  a_stop: assert property (p_stop) else $error("oe at stop");
  property p_start; scl_i && $fell(sda_i) |=> !sda_oe [*4]; endproperty
  a_start: assert property (p_start) else $error("oe at start");
  property p_rose; $rose(sda_oe) |-> sda_oe [*8]; endproperty
  a_rose: assert property (p_rose) else $error("short drive");
  property p_hold; sda_oe && $rose(scl_i) |-> sda_oe [*8]; endproperty
  a_hold: assert property (p_hold) else $error("drop in high");
endmodule
bind nvm_i2c_slave nvm_i2c_slave_monitor #(.AW(AW), .DEPTH(DEPTH)) mon_i (
  .clk(clk), .nrst(nrst), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .strap_addr_bit2(strap_addr_bit2),
  .strap_addr_bit1(strap_addr_bit1), .strap_addr_bit0(strap_addr_bit0),
  .write_protect(write_protect));

// *** verif/nvm_ctl.sv ***
// Behavioural two-wire bus controller driving the serial clock.
`timescale 1ns/100ps
module nvm_ctl (
  // Clock out, pull-down request, resolved data in.
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // *****
  // Bus actions
  // *****
  // Half bit of 40 ns, a bus clock period of 80 ns; five system clocks a
  // phase still leave room for the target's three-clock input lag.
  localparam time H = 40ns;
  // Lines start released; the clock stands high between frames.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    sda_low = 1'b0;
    #H scl = 1'b1;
    #H sda_low = 1'b1;
    #H scl = 1'b0;
  endtask
  // Stop: data rises while the clock is high.
  task automatic stop();
    sda_low = 1'b1;
    #H scl = 1'b1;
    #H sda_low = 1'b0;
    #H;
  endtask
  // One clock; a one only releases, never drives high.
  task automatic bit_x(input logic b, output logic r);
    sda_low = !b;
    #H scl = 1'b1;
    #(H/2) r = sda;
    #(H/2) scl = 1'b0;
  endtask
  // Recovery: nine clocks with data released, then a stop.
  task automatic recover();
    sda_low = 1'b0;
    repeat (9) begin
      #H scl = 1'b1;
      #H scl = 1'b0;
    end
    stop();
  endtask
  // Eight bits, first bit most significant, then the ninth clock.
  task automatic xfer(input logic [7:0] d, input logic k,
      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(k, ack);
  endtask
endmodule

// *** verif/tb_nvm_i2c_slave.sv ***
// Self-checking bench for the two-wire memory target.
`timescale 1ns/100ps
module tb_nvm_i2c_slave;
  import nvm_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wp = 1'b0;
  logic [2:0] strap = 3'b110;
  logic scl, sda_low, sda_oe, sda_o, a;
  logic [7:0] q;
  int n_mismatch = 0;
  int n_compared = 0;
  // Rows of address and byte, written then read back.
  logic [20:0] rows [4] = '{{13'h0100, 8'h11}, {13'h0101, 8'h22},
    {13'h0102, 8'h33}, {13'h0aaa, 8'hc3}};
  // Open-drain wire with pull-up.
  wire sda = !((sda_oe && !sda_o) || sda_low);
  nvm_ctl nvm_ctl_i (.scl(scl), .sda_low(sda_low), .sda(sda));
  nvm_i2c_slave nvm_i2c_slave_i (.clk(clk), .nrst(nrst), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .strap_addr_bit2(strap[2]), .strap_addr_bit1(strap[1]),
    .strap_addr_bit0(strap[0]), .write_protect(wp));
  // *****
  // Tasks
  // *****
  task automatic ck(string n, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic ck1(string n, logic e, logic g);
    ck(n, {7'h0, e}, {7'h0, g});
  endtask
  task automatic sel(logic [7:0] w, logic e);
    nvm_ctl_i.start();
    nvm_ctl_i.xfer(w, 1'b1, q, a);
    ck1("ack_addr", e, a);
  endtask
  task automatic wb(logic [7:0] d);
    nvm_ctl_i.xfer(d, 1'b1, q, a);
    ck1("ack_byte", 1'b0, a);
  endtask
  // Loads the counter; high bits 7:5 sent as zero.
  task automatic go(logic [12:0] ad);
    sel({NVM_TYPE_CODE, strap, NVM_DIR_WRITE}, 1'b0);
    wb({3'h0, ad[12:8]});
    wb(ad[7:0]);
  endtask
  task automatic rb(logic [7:0] e, logic last);
    nvm_ctl_i.xfer(8'hff, last, q, a);
    ck("rdata", e, q);
  endtask
  task automatic rd(logic [7:0] e);
    sel({NVM_TYPE_CODE, strap, NVM_DIR_READ}, 1'b0);
    rb(e, 1'b1);
    nvm_ctl_i.stop();
  endtask
  task automatic print_verdict();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Clock and watchdog; the run needs well under 100 us.
  initial begin
    forever #4 clk = ~clk;
  end
  initial begin
    #200us;
    n_mismatch++;
    print_verdict();
  end
  // *****
  // Sequence
  // *****
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    ck1("oe_idle", 1'b0, sda_oe);
    ck1("sda_o", 1'b0, sda_o);
    // Keep bus edges two nanoseconds off the sampling clock edge.
    #2;
    foreach (rows[i]) begin
      go(rows[i][20:8]);
      wb(rows[i][7:0]);
      nvm_ctl_i.stop();
      go(rows[i][20:8]);
      rd(rows[i][7:0]);
    end
    // Protected bytes are acked, dropped, and still move the counter.
    @(posedge clk) wp <= 1'b1;
    #2;
    go(13'h0100);
    wb(8'hee);
    wb(8'hee);
    nvm_ctl_i.stop();
    rd(8'h33);
    @(posedge clk) wp <= 1'b0;
    #2;
    go(13'h0100);
    rd(8'h11);
    // Page write and sequential read across the top address.
    go(13'h1fff);
    wb(8'h7e);
    wb(8'h81);
    wb(8'h99);
    nvm_ctl_i.stop();
    go(13'h1fff);
    sel({NVM_TYPE_CODE, strap, NVM_DIR_READ}, 1'b0);
    rb(8'h7e, 1'b0);
    rb(8'h81, 1'b1);
    nvm_ctl_i.stop();
    rd(8'h99);
    // A stop inside a data byte must leave the array alone.
    go(13'h0aaa);
    repeat (4) nvm_ctl_i.bit_x(1'b0, a);
    nvm_ctl_i.stop();
    nvm_ctl_i.recover();
    go(13'h0aaa);
    rd(8'hc3);
    // Reversed straps and a wrong type code get no answer.
    sel({NVM_TYPE_CODE, 3'b011, NVM_DIR_READ}, 1'b1);
    sel({~NVM_TYPE_CODE, strap, NVM_DIR_READ}, 1'b1);
    nvm_ctl_i.stop();
    print_verdict();
  end
endmodule
